// File: core/scs_sequencer.sv
// SAR conversion sequencer: start sync, aperture, 18 trials, result latch.
// Assumes convert_start is an asynchronous pin and comp_keep is a
// settled comparator decision valid at the end of each trial step.
`timescale 1ns/1ps
`include "scs_defines.svh"

module scs_sequencer
    import scs_pkg::*;
#(
    parameter int unsigned DATA_W       = `SCS_DATA_W,
    parameter int unsigned APERTURE_CYC = `SCS_APERTURE_CYC,
    parameter int unsigned STEP_CYC     = `SCS_STEP_CYC
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              srst,
    // Host pin
    input  wire logic              convert_start,
    // Comparator
    input  wire logic              comp_keep,
    // Analog array control
    output scs_switch_t            array_switches,
    output logic [DATA_W-1:0]      dac_code,
    output logic                   power_down,
    // Result
    output logic                   busy,
    output logic                   result_valid,
    output logic [DATA_W-1:0]      result_code
);

    scs_state_t          state;
    scs_state_t          next_state;
    logic [2:0]          sync;
    logic                start_lvl;
    logic                next_start_lvl;
    logic                start_acc;
    logic [7:0]          cnt;
    logic [7:0]          next_cnt;
    logic [4:0]          bit_idx;
    logic [4:0]          next_bit_idx;
    logic [DATA_W-1:0]   next_dac_code;
    logic [DATA_W-1:0]   next_result_code;
    logic                next_busy;
    logic                next_result_valid;
    logic                step_end;
    scs_switch_t         next_switches;
    logic                next_power_down;

    // Level changes only once the two later stages agree
    always_comb begin
        next_start_lvl = (sync[1] == sync[2]) ? sync[1] : start_lvl;
    end

    // Starts while converting are ignored; host waits for done
    assign start_acc = (state == ST_ACQ) && next_start_lvl && !start_lvl;
    assign step_end  = (cnt == 8'(STEP_CYC - 1));

    always_comb begin
        next_state        = state;
        next_cnt          = cnt;
        next_bit_idx      = bit_idx;
        next_dac_code     = dac_code;
        next_result_code  = result_code;
        next_busy         = busy;
        next_result_valid = 1'b0;
        unique case (state)
            ST_ACQ: begin
                if (start_acc) begin
                    next_state = ST_OPEN;
                    next_cnt   = 8'h00;
                    next_busy  = 1'b1;
                end
            end
            ST_OPEN: begin
                if (cnt == 8'(APERTURE_CYC - 1)) begin
                    next_state    = ST_TRIAL;
                    next_cnt      = 8'h00;
                    next_bit_idx  = 5'(DATA_W - 1);
                    next_dac_code = `SCS_MSB_TRIAL;
                end else begin
                    next_cnt = cnt + 8'h01;
                end
            end
            ST_TRIAL: begin
                // Steps paced by internal count only, no serial clock
                if (step_end) begin
                    next_cnt = 8'h00;
                    if (!comp_keep) begin
                        next_dac_code[bit_idx] = 1'b0;
                    end
                    if (bit_idx == 5'h00) begin
                        next_state = ST_DONE;
                    end else begin
                        next_bit_idx                  = bit_idx - 5'h01;
                        next_dac_code[bit_idx - 5'h01] = 1'b1;
                    end
                end else begin
                    next_cnt = cnt + 8'h01;
                end
            end
            ST_DONE: begin
                // Offset binary to two's complement; range ends saturate
                next_result_code  = {~dac_code[DATA_W-1], dac_code[DATA_W-2:0]};
                next_result_valid = 1'b1;
                next_busy         = 1'b0;
                next_state        = ST_ACQ;
            end
        endcase
    end

    // Switch pattern follows the next state so outputs stay registered
    always_comb begin
        next_switches   = '{1'b1, 1'b1, 1'b1};
        next_power_down = (next_state == ST_ACQ);
        unique case (next_state)
            ST_ACQ:   next_switches = '{1'b1, 1'b1, 1'b1};
            ST_OPEN:  next_switches = '{1'b0, 1'b0, 1'b1};
            ST_TRIAL: next_switches = '{1'b0, 1'b0, 1'b0};
            ST_DONE:  next_switches = '{1'b0, 1'b0, 1'b0};
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state          <= ST_ACQ;
            sync           <= 3'h0;
            start_lvl      <= 1'b0;
            cnt            <= 8'h00;
            bit_idx        <= 5'h00;
            dac_code       <= `SCS_CODE_RST;
            result_code    <= `SCS_CODE_RST;
            busy           <= 1'b0;
            result_valid   <= 1'b0;
            array_switches <= '{1'b1, 1'b1, 1'b1};
            power_down     <= 1'b1;
        end else begin
            state          <= next_state;
            sync           <= {sync[1:0], convert_start};
            start_lvl      <= next_start_lvl;
            cnt            <= next_cnt;
            bit_idx        <= next_bit_idx;
            dac_code       <= next_dac_code;
            result_code    <= next_result_code;
            busy           <= next_busy;
            result_valid   <= next_result_valid;
            array_switches <= next_switches;
            power_down     <= next_power_down;
        end
    end

    property p_open_first;
        @(posedge core_clk) disable iff (srst)
        start_acc |=> !array_switches.positive_array_ground_switch
            && !array_switches.negative_array_ground_switch
            && array_switches.input_connect;
    endproperty
    a_open_first: assert property (p_open_first) else $error("switch order wrong");

    property p_aperture;
        @(posedge core_clk) disable iff (srst)
        start_acc |=> array_switches.input_connect [*2] ##1 !array_switches.input_connect;
    endproperty
    a_aperture: assert property (p_aperture) else $error("hold not at aperture");

    property p_msb_first;
        @(posedge core_clk) disable iff (srst)
        $rose(state == ST_TRIAL) |-> dac_code == `SCS_MSB_TRIAL;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial not MSB");

    property p_step_count;
        @(posedge core_clk) disable iff (srst)
        $rose(state == ST_TRIAL) |-> ##89 (state == ST_TRIAL) ##1 (state == ST_DONE);
    endproperty
    a_step_count: assert property (p_step_count) else $error("trial count wrong");

    property p_done;
        @(posedge core_clk) disable iff (srst)
        state == ST_DONE |=> state == ST_ACQ && result_valid && !busy && power_down;
    endproperty
    a_done: assert property (p_done) else $error("completion not signalled");

    property p_step_pace;
        @(posedge core_clk) disable iff (srst)
        (state == ST_TRIAL) && step_end && (bit_idx != 5'h00)
            |=> bit_idx == $past(bit_idx) - 5'h01 && cnt == 8'h00;
    endproperty
    a_step_pace: assert property (p_step_pace) else $error("step pacing wrong");

    property p_twos;
        @(posedge core_clk) disable iff (srst)
        result_valid |-> result_code == {~dac_code[DATA_W-1], dac_code[DATA_W-2:0]};
    endproperty
    a_twos: assert property (p_twos) else $error("result not own sample");

    property p_sat;
        @(posedge core_clk) disable iff (srst)
        result_valid && (dac_code == '1) |-> result_code == `SCS_CODE_POS_SAT;
    endproperty
    a_sat: assert property (p_sat) else $error("positive end not saturated");

    property p_sat_neg;
        @(posedge core_clk) disable iff (srst)
        result_valid && (dac_code == '0) |-> result_code == `SCS_CODE_NEG_SAT;
    endproperty
    a_sat_neg: assert property (p_sat_neg) else $error("negative end not saturated");

    // Powered down only while idle, never in the middle of a conversion
    property p_power;
        @(posedge core_clk) disable iff (srst)
        power_down == !busy;
    endproperty
    a_power: assert property (p_power) else $error("power state disagrees with busy");

    property p_stable;
        @(posedge core_clk) disable iff (srst)
        !result_valid |-> ##1 (result_valid || $stable(result_code));
    endproperty
    a_stable: assert property (p_stable) else $error("result changed early");

    property p_busy_window;
        @(posedge core_clk) disable iff (srst)
        start_acc |=> busy ##[1:100] !busy;
    endproperty
    a_busy_window: assert property (p_busy_window) else $error("conversion too long");

endmodule : scs_sequencer

// File: common/scs_defines.svh
// Timing and code constants for the SAR conversion sequencer.
// Assumes a single 50 MHz core clock; included by bare name.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_DATA_W          18
`define SCS_CLK_PERIOD_NS   20
`define SCS_APERTURE_NS     40
`define SCS_APERTURE_CYC    ((`SCS_APERTURE_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_STEP_NS         100
`define SCS_STEP_CYC        ((`SCS_STEP_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_MSB_TRIAL       18'h20000
`define SCS_CODE_POS_SAT    18'h1FFFF
`define SCS_CODE_NEG_SAT    18'h20000
`define SCS_CODE_RST        18'h00000

`endif

// File: common/scs_pkg.sv
// Types for the SAR conversion sequencer.
// Constants live in scs_defines.svh.
package scs_pkg;

    typedef enum logic [2:0] {
        ST_ACQ,
        ST_OPEN,
        ST_TRIAL,
        ST_DONE
    } scs_state_t;

    // Array switch controls; a one closes the switch
    typedef struct packed {
        logic positive_array_ground_switch;
        logic negative_array_ground_switch;
        logic input_connect;
    } scs_switch_t;

endpackage : scs_pkg

// File: tb/scs_comp_model.sv
// Comparator and sampling array seen from the sequencer.
// Assumes vin is in LSB units and dac_code is an offset-binary trial word.
`timescale 1ns/1ps
module scs_comp_model
    import scs_pkg::*;
(
    // Clock and analog stand-in
    input  wire logic               core_clk,
    input  wire logic signed [31:0] vin,
    // Sequencer side
    input  wire scs_switch_t        array_switches,
    input  wire logic [17:0]        dac_code,
    output logic                    comp_keep
);
    logic signed [31:0] off;
    logic [17:0]        held;
    assign off = vin + 32'sd131072;
    // Tracks while connected, frozen once the arrays leave the inputs
    always_ff @(posedge core_clk) begin
        if (array_switches.input_connect) begin
            held <= (off < 0) ? 18'h00000 : (off > 262143) ? 18'h3FFFF : off[17:0];
        end
    end
    assign comp_keep = (dac_code <= held);
endmodule : scs_comp_model

// File: tb/testbench.sv
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model answers within the same cycle.
`timescale 1ns/1ps
module testbench;
    import scs_pkg::*;
    typedef struct { int vin; logic [17:0] code; } scs_row_t;
    logic               core_clk = 1'b0;
    logic               srst = 1'b1;
    logic               convert_start = 1'b0;
    logic signed [31:0] vin = 0;
    logic               comp_keep, busy, power_down, result_valid;
    scs_switch_t        array_switches;
    logic [17:0]        dac_code, result_code;
    int                 n_fail = 0;
    int                 cmp_count = 0;
    scs_row_t rows[9] = '{'{0, 18'h00000}, '{1, 18'h00001}, '{-1, 18'h3FFFF},
        '{-131071, 18'h20001}, '{131071, 18'h1FFFF}, '{200000, 18'h1FFFF},
        '{-131072, 18'h20000}, '{-200000, 18'h20000}, '{12345, 18'h03039}};
    always #10 core_clk = ~core_clk;
    scs_sequencer dut (.core_clk(core_clk), .srst(srst), .convert_start(convert_start),
        .comp_keep(comp_keep), .array_switches(array_switches), .dac_code(dac_code),
        .power_down(power_down), .busy(busy), .result_valid(result_valid),
        .result_code(result_code));
    scs_comp_model partner (.core_clk(core_clk), .vin(vin), .array_switches(array_switches),
        .dac_code(dac_code), .comp_keep(comp_keep));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Input moved after the hold, so a late sample shows up as a wrong code
    task automatic convert(input int v, input bit rerise);
        int n;
        n = 0;
        @(posedge core_clk);
        vin <= v;
        convert_start <= 1'b1;
        do begin @(negedge core_clk); n++; end while (busy !== 1'b1 && n < 20);
        chk(18'(array_switches), 18'h1);
        do begin @(negedge core_clk); n++; end while (array_switches.input_connect && n < 20);
        chk(dac_code, 18'h20000);
        chk(18'(array_switches), 18'h0);
        @(posedge core_clk);
        convert_start <= 1'b0;
        vin <= 777;
        if (rerise) begin
            repeat (3) @(posedge core_clk);
            convert_start <= 1'b1;
        end
        do begin @(negedge core_clk); n++; end while (result_valid !== 1'b1 && n < 200);
        chk(busy, 1'b0);
        chk(power_down, 1'b1);
        chk(n <= 125, 1'b1);
    endtask : convert
    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            convert(rows[i].vin, 1'b0);
            chk(result_code, rows[i].code);
            @(negedge core_clk);
            chk(result_valid, 1'b0);
        end
        // Rise during busy is dropped; a held level starts nothing
        convert(-5, 1'b1);
        chk(result_code, 18'h3FFFB);
        repeat (20) begin
            @(negedge core_clk);
            chk(busy, 1'b0);
            chk(result_code, 18'h3FFFB);
        end
        @(posedge core_clk);
        convert_start <= 1'b0;
        // Reset in mid-conversion
        repeat (4) @(posedge core_clk);
        convert_start <= 1'b1;
        repeat (30) @(posedge core_clk);
        srst <= 1'b1;
        convert_start <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(busy, 1'b0);
        chk(power_down, 1'b1);
        chk(18'(array_switches), 18'h7);
        chk(result_code, 18'h00000);
        @(posedge core_clk);
        srst <= 1'b0;
        convert(3, 1'b0);
        chk(result_code, 18'h00003);
        wrap_up();
    end
endmodule : testbench
